// *** rtl/fhsp_pkg.sv ***
// Constants shared by both ends of the floppy host status port.
// Assumes one 50 MHz clock and an active-high asynchronous reset.
// Overview of operation
// R1: Three ports: data, status, rate select.
// R2: Status readable, rate writable at any time.
// R3: Host touches data only on grant/request.
// R4: Host polls ready, then writes command bytes.
// R5: Status bit 7 grants data port access.
// R6: Bit 6 direction; one means host reads.
// R7: Bit 5 set in polled execution phase.
// R8: Bit 5 separates execution from result.
// R9: Request threshold programmable over 16 bytes.
// R10: Powerdown resets, stops oscillator; reset restarts.
// R11: Wait 1 ms after powerdown before use.
// R12: Timing derives from reference clock by rate.
// R13: Reset gives legacy defaults for extensions.
// R14: Scan commands treated as unsupported.
// R15: Recalibrate issues up to 255 steps.
// R16: Direction low outward, high inward.
// R17: Head load driven when drive needs it.
// R18: Drive ready input gates operations.
// R19: Grant drops after each command byte write.
// R20: Bit 4 busy from command to result end.
// R21: Bits 3..0 seek busy; reads side-effect free.
package fhsp_pkg;
	localparam logic [1:0] FHSP_PORT_STATUS = 2'h0;
	localparam logic [1:0] FHSP_PORT_DATA = 2'h1;
	localparam logic [1:0] FHSP_PORT_RATE = 2'h2;
	localparam logic [1:0] FHSP_REG_CMD = 2'h0;
	localparam logic [1:0] FHSP_REG_STAT = 2'h1;
	localparam logic [1:0] FHSP_REG_RES = 2'h2;
	localparam logic [1:0] FHSP_REG_CFG = 2'h3;
	localparam int FHSP_BIT_GRANT = 7;
	localparam int FHSP_BIT_DIR = 6;
	localparam int FHSP_BIT_POLL = 5;
	localparam int FHSP_BIT_BUSY = 4;
	localparam logic [7:0] FHSP_CMD_SPECIFY = 8'h03;
	localparam logic [7:0] FHSP_CMD_RECAL = 8'h07;
	localparam logic [7:0] FHSP_CMD_SEEK = 8'h0f;
	localparam logic [7:0] FHSP_CMD_READ = 8'h06;
	localparam logic [7:0] FHSP_CMD_CONFIG = 8'h13;
	localparam logic [4:0] FHSP_CMD_SCAN_A = 5'h11;
	localparam logic [4:0] FHSP_CMD_SCAN_B = 5'h19;
	localparam logic [4:0] FHSP_CMD_SCAN_C = 5'h1d;
	localparam logic [7:0] FHSP_ST_INVALID = 8'h80;
	localparam logic [7:0] FHSP_RATE_RESET = 8'h02;
	localparam logic [7:0] FHSP_MAX_STEPS = 8'hff;
	localparam int FHSP_FIFO_DEPTH = 16;
	localparam int FHSP_CLK_HZ = 50000000;
	localparam int FHSP_STABLE_US = 1000;
	localparam int FHSP_STABLE_CYC = FHSP_CLK_HZ / 1000000 * FHSP_STABLE_US;
	localparam int FHSP_STEP_US = 4;
	localparam int FHSP_STEP_CYC = FHSP_CLK_HZ / 1000000 * FHSP_STEP_US;
	localparam int FHSP_RATE_DIV_500K = 100;
	function automatic logic [7:0] fhsp_param_count(input logic [7:0] cmd);
		case (cmd)
		FHSP_CMD_SPECIFY: fhsp_param_count = 8'h02;
		FHSP_CMD_RECAL: fhsp_param_count = 8'h01;
		FHSP_CMD_SEEK: fhsp_param_count = 8'h02;
		FHSP_CMD_READ: fhsp_param_count = 8'h01;
		FHSP_CMD_CONFIG: fhsp_param_count = 8'h01;
		default: fhsp_param_count = 8'h00;
		endcase
	endfunction
endpackage

// *** rtl/fhsp_if.sv ***
// Parallel bus between the host end and the controller end.
// Assumes both ends share clock_i.
`timescale 1ns/1ps
`default_nettype none
interface fhsp_if;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic dma_service_req;
	logic dma_ack;
	modport dev(input addr, input wdata, input wr, input rd, input dma_ack,
		output rdata, output dma_service_req);
	modport host(output addr, output wdata, output wr, output rd,
		output dma_ack, input rdata, input dma_service_req);
endinterface
`default_nettype wire

// *** rtl/fhsp_device.sv ***
// Controller end: status, data port, rate select, drive pins.
// Assumes the host end keeps to grant and request before data access.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fhsp_device #(
	parameter int STABLE_CYC = fhsp_pkg::FHSP_STABLE_CYC,
	parameter int DEPTH = fhsp_pkg::FHSP_FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic rst_i,
	fhsp_if.dev bus,
	input wire logic drive_ready_i,
	input wire logic track0_i,
	output logic head_load_out_o,
	output logic step_pulse_out_o,
	output logic seek_dir_o,
	output logic osc_enable_o,
	output logic clock_stable_o
);
	import fhsp_pkg::*;
	typedef enum logic [2:0] {
		FHSP_IDLE = 3'b000, FHSP_PARAM = 3'b001, FHSP_EXEC = 3'b011,
		FHSP_RESULT = 3'b010, FHSP_DOWN = 3'b110
	} fhsp_state_t;
	fhsp_state_t state_reg;
	logic rdy_s1_reg, rdy_reg, trk_s1_reg, trk_reg;
	logic [7:0] cmd_reg, left_reg, rate_reg, result_reg, steps_reg;
	logic [3:0] thr_reg;
	logic poll_mode_reg, grant_reg, fifo_en_reg, seeking_reg, tick_seen_reg;
	logic [31:0] stab_reg, step_cnt_reg, rate_cnt_reg;
	logic data_wr, data_rd, rate_tick;
	localparam logic [7:0] FHSP_CMD_POWERDOWN_ALIAS = 8'h17;
	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdy_s1_reg <= 1'b0;
			rdy_reg <= 1'b0;
			trk_s1_reg <= 1'b0;
			trk_reg <= 1'b0;
		end else begin
			rdy_s1_reg <= drive_ready_i;
			rdy_reg <= rdy_s1_reg;
			trk_s1_reg <= track0_i;
			trk_reg <= trk_s1_reg;
		end
	end
	// ------------------------------------------------------------------
	// Host decode
	// ------------------------------------------------------------------
	assign data_wr = bus.wr && bus.addr == FHSP_PORT_DATA;
	assign data_rd = bus.rd && bus.addr == FHSP_PORT_DATA;
	// Status reads have no side effect so polling can never disturb state.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bus.rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
			FHSP_PORT_STATUS: begin
				bus.rdata <= {grant_reg, state_reg == FHSP_RESULT, // R5 R6
					poll_mode_reg && state_reg == FHSP_EXEC, // R7 R8
					state_reg != FHSP_IDLE && state_reg != FHSP_DOWN, // R20
					3'h0, seeking_reg}; // R21 R2
			end
			FHSP_PORT_DATA: bus.rdata <= result_reg; // R1
			default: bus.rdata <= 8'h00;
			endcase
		end
	end
	// ------------------------------------------------------------------
	// Rate select and timing
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rate_reg <= FHSP_RATE_RESET; // R13
		end else if (bus.wr && bus.addr == FHSP_PORT_RATE) begin
			rate_reg <= bus.wdata; // R2
		end
	end
	// Byte clock scaled from the reference by the selected rate.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rate_cnt_reg <= 32'h0;
		end else if (rate_tick) begin
			rate_cnt_reg <= 32'h0;
		end else begin
			rate_cnt_reg <= rate_cnt_reg + 32'h1; // R12
		end
	end
	assign rate_tick = rate_cnt_reg >=
		32'(FHSP_RATE_DIV_500K) * {30'h0, rate_reg[1:0]} + 32'(FHSP_RATE_DIV_500K);
	// ------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= FHSP_IDLE;
			cmd_reg <= 8'h00;
			left_reg <= 8'h00;
			result_reg <= 8'h00;
			grant_reg <= 1'b0;
			poll_mode_reg <= 1'b0; // R13
			fifo_en_reg <= 1'b0;
			thr_reg <= 4'h0;
			stab_reg <= 32'h0;
			seeking_reg <= 1'b0;
			steps_reg <= 8'h00;
			step_cnt_reg <= 32'h0;
			tick_seen_reg <= 1'b0;
		end else begin
			if (stab_reg < 32'(STABLE_CYC)) begin
				stab_reg <= stab_reg + 32'h1; // R11
			end
			case (state_reg)
			FHSP_IDLE: begin
				grant_reg <= clock_stable_o && !data_wr; // R19 R11
				if (data_wr && grant_reg) begin
					cmd_reg <= bus.wdata;
					left_reg <= fhsp_param_count(bus.wdata);
					if (bus.wdata == FHSP_CMD_POWERDOWN_ALIAS) begin
						state_reg <= FHSP_DOWN; // R10
					end else if (bus.wdata[4:0] == FHSP_CMD_SCAN_A ||
						bus.wdata[4:0] == FHSP_CMD_SCAN_B ||
						bus.wdata[4:0] == FHSP_CMD_SCAN_C ||
						fhsp_param_count(bus.wdata) == 8'h00) begin
						result_reg <= FHSP_ST_INVALID; // R14
						state_reg <= FHSP_RESULT;
					end else begin
						state_reg <= FHSP_PARAM;
					end
				end
			end
			FHSP_PARAM: begin
				grant_reg <= !data_wr && left_reg != 8'h00; // R19
				if (data_wr && grant_reg) begin
					left_reg <= left_reg - 8'h01;
					if (cmd_reg == FHSP_CMD_SPECIFY && left_reg == 8'h01) begin
						poll_mode_reg <= bus.wdata[0];
					end
					if (cmd_reg == FHSP_CMD_CONFIG) begin
						fifo_en_reg <= bus.wdata[4];
						thr_reg <= bus.wdata[3:0]; // R9
					end
					if (left_reg == 8'h01) begin
						state_reg <= FHSP_EXEC;
						tick_seen_reg <= 1'b0;
						if (cmd_reg == FHSP_CMD_RECAL) begin
							seeking_reg <= rdy_reg; // R18
							steps_reg <= FHSP_MAX_STEPS; // R15
						end
						if (cmd_reg == FHSP_CMD_SEEK) begin
							seeking_reg <= rdy_reg; // R18
							steps_reg <= bus.wdata;
						end
					end
				end
			end
			FHSP_EXEC: begin
				grant_reg <= 1'b0;
				if (seeking_reg) begin
					step_cnt_reg <= step_cnt_reg + 32'h1;
					if (step_cnt_reg == 32'(2 * FHSP_STEP_CYC - 1)) begin
						step_cnt_reg <= 32'h0;
						steps_reg <= steps_reg - 8'h01;
						if (steps_reg == 8'h01 ||
							(cmd_reg == FHSP_CMD_RECAL && trk_reg)) begin
							seeking_reg <= 1'b0;
							state_reg <= FHSP_IDLE; // R20
						end
					end
				end else if (cmd_reg == FHSP_CMD_READ) begin
					// A full byte time in execution lets polling see bit 5.
					if (rate_tick && tick_seen_reg) begin
						result_reg <= {fifo_en_reg, 3'h0, thr_reg};
						state_reg <= FHSP_RESULT;
					end else if (rate_tick) begin
						tick_seen_reg <= 1'b1;
					end
				end else if (cmd_reg == FHSP_CMD_RECAL || cmd_reg == FHSP_CMD_SEEK) begin
					state_reg <= FHSP_IDLE;
				end else begin
					state_reg <= FHSP_IDLE;
				end
			end
			FHSP_RESULT: begin
				grant_reg <= !data_rd;
				if (data_rd && grant_reg) begin
					state_reg <= FHSP_IDLE; // R20
				end
			end
			FHSP_DOWN: begin
				grant_reg <= 1'b0;
				// The oscillator is off, so the settling wait starts over.
				stab_reg <= 32'h0; // R11
			end
			default: state_reg <= FHSP_IDLE;
			endcase
		end
	end
	// ------------------------------------------------------------------
	// Drive pins and oscillator
	// ------------------------------------------------------------------
	assign step_pulse_out_o = seeking_reg && step_cnt_reg < 32'(FHSP_STEP_CYC);
	// Recalibrate always heads outward; a seek is taken as inward.
	assign seek_dir_o = cmd_reg != FHSP_CMD_RECAL; // R16
	assign head_load_out_o = state_reg == FHSP_EXEC && rdy_reg; // R17
	// Only an external reset leaves powerdown, which also restarts the wait.
	assign osc_enable_o = state_reg != FHSP_DOWN; // R10
	assign clock_stable_o = stab_reg >= 32'(STABLE_CYC); // R11
	assign bus.dma_service_req = state_reg == FHSP_EXEC && !poll_mode_reg &&
		cmd_reg == FHSP_CMD_READ && rate_tick && tick_seen_reg; // R7
	logic unused_ack;
	assign unused_ack = bus.dma_ack;
endmodule
`default_nettype wire

// *** rtl/fhsp_host.sv ***
// Host end: polls status and sends one command with its parameters.
// Assumes the controller end answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module fhsp_host (
	input wire logic clock_i,
	input wire logic rst_i,
	fhsp_if.host bus,
	input wire logic start_i,
	input wire logic [7:0] cmd_i,
	input wire logic [7:0] param0_i,
	input wire logic [7:0] param1_i,
	input wire logic [1:0] nparam_i,
	output logic busy_o,
	output logic [7:0] result_o,
	output logic result_valid_o
);
	import fhsp_pkg::*;
	typedef enum logic [2:0] {
		FHSP_H_IDLE = 3'b000, FHSP_H_POLL = 3'b001, FHSP_H_SWAIT = 3'b011,
		FHSP_H_WAIT = 3'b010, FHSP_H_RWAIT = 3'b110, FHSP_H_READ = 3'b111
	} fhsp_host_state_t;
	fhsp_host_state_t state_reg;
	logic [1:0] idx_reg;
	logic [7:0] st;
	assign st = bus.rdata;
	assign busy_o = state_reg != FHSP_H_IDLE;
	assign bus.dma_ack = 1'b0;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= FHSP_H_IDLE;
			idx_reg <= 2'h0;
			bus.addr <= FHSP_PORT_STATUS;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			result_o <= 8'h00;
			result_valid_o <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			result_valid_o <= 1'b0;
			case (state_reg)
			FHSP_H_IDLE: begin
				if (start_i) begin
					idx_reg <= 2'h0;
					state_reg <= FHSP_H_POLL;
				end
			end
			FHSP_H_POLL: begin
				bus.addr <= FHSP_PORT_STATUS;
				bus.rd <= 1'b1; // R4
				state_reg <= FHSP_H_SWAIT;
			end
			// Status data stand from the cycle after the strobe until the next read.
			FHSP_H_SWAIT: begin
				state_reg <= FHSP_H_WAIT;
			end
			FHSP_H_WAIT: begin
				if (st[FHSP_BIT_GRANT] && st[FHSP_BIT_DIR]) begin // R6
					bus.addr <= FHSP_PORT_DATA;
					bus.rd <= 1'b1; // R3
					state_reg <= FHSP_H_RWAIT;
				end else if (st[FHSP_BIT_GRANT] && idx_reg <= nparam_i) begin // R3
					bus.addr <= FHSP_PORT_DATA;
					bus.wr <= 1'b1;
					bus.wdata <= idx_reg == 2'h0 ? cmd_i :
						idx_reg == 2'h1 ? param0_i : param1_i; // R4
					idx_reg <= idx_reg + 2'h1;
					state_reg <= FHSP_H_POLL;
				end else if (!st[FHSP_BIT_BUSY] && idx_reg > nparam_i) begin
					state_reg <= FHSP_H_IDLE;
				end else begin
					state_reg <= FHSP_H_POLL;
				end
			end
			FHSP_H_RWAIT: begin
				state_reg <= FHSP_H_READ;
			end
			FHSP_H_READ: begin
				result_o <= st;
				result_valid_o <= 1'b1;
				state_reg <= FHSP_H_POLL;
			end
			default: state_reg <= FHSP_H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/fhsp_bus_checker.sv ***
// Assertions on the bus that joins the host end and the controller end.
// Assumes it sits beside the interface on the shared clock and reset.
`timescale 1ns/1ps
`default_nettype none
module fhsp_bus_checker
	import fhsp_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic dma_service_req,
	input wire logic dma_ack
);
	// ------
	// Helpers
	// ------
	logic stat_d;
	logic grant_ok;
	logic dir_ok;
	logic wr_data;
	logic rd_data;
	assign wr_data = wr && (addr == FHSP_PORT_DATA);
	assign rd_data = rd && (addr == FHSP_PORT_DATA);
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stat_d <= 1'b0;
		end else begin
			stat_d <= rd && (addr == FHSP_PORT_STATUS);
		end
	end
	// A write spends the grant, so the host has to poll again.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			grant_ok <= 1'b0;
			dir_ok <= 1'b0;
		end else if (wr_data) begin
			grant_ok <= 1'b0;
		end else if (stat_d) begin
			grant_ok <= rdata[FHSP_BIT_GRANT];
			dir_ok <= !rdata[FHSP_BIT_DIR];
		end
	end
	// ------
	// Properties
	// ------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	sequence s_stat_reply;
		rd && (addr == FHSP_PORT_STATUS) ##1 1'b1;
	endsequence
	sequence s_write_then_poll;
		wr_data ##1 (rd && (addr == FHSP_PORT_STATUS));
	endsequence
	chk_one_strobe: assert property (!(wr && rd))
		else $error("write and read strobes together");
	chk_wr_granted: assert property (wr_data |->
		(stat_d ? rdata[FHSP_BIT_GRANT] : grant_ok))
		else $error("data write without grant");
	chk_rd_granted: assert property (rd_data |->
		(stat_d ? rdata[FHSP_BIT_GRANT] : grant_ok))
		else $error("data read without grant");
	chk_wr_dir_in: assert property (wr_data |->
		(stat_d ? !rdata[FHSP_BIT_DIR] : dir_ok))
		else $error("data write while direction is out");
	chk_wr_single: assert property (wr |=> !wr)
		else $error("data writes back to back");
	chk_grant_drops: assert property (s_write_then_poll |=>
		!rdata[FHSP_BIT_GRANT])
		else $error("grant still set after write");
	chk_rdata_holds: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	chk_poll_busy: assert property (s_stat_reply |->
		(!rdata[FHSP_BIT_POLL] || rdata[FHSP_BIT_BUSY]))
		else $error("polled flag outside a command");
	chk_dir_busy: assert property (s_stat_reply |->
		(!rdata[FHSP_BIT_DIR] || rdata[FHSP_BIT_BUSY]))
		else $error("direction out outside a command");
	chk_dreq_pulse: assert property (dma_service_req |=> !dma_service_req)
		else $error("service request longer than one cycle");
endmodule
`default_nettype wire

// *** tb/floppy_host_status_port_test.sv ***
// Bench: host end and controller end joined, checked against a model.
// Assumes the package, interface, both ends and the checker come first.
`timescale 1ns/1ps
`default_nettype none
module floppy_host_status_port_test;
	import fhsp_pkg::*;
	// ------
	// Wiring
	// ------
	localparam int STABLE = 20;
	logic clock_i, rst_i, drive_ready_i, track0_i, start_i, busy_o;
	logic head_o, step_o, dir_o, osc_o, stable_o, valid_o;
	logic [7:0] cmd_i, p0_i, p1_i, res_o;
	logic [1:0] np_i;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	logic exp_dir, step_prev, stat_pend;
	logic [3:0] thr;
	int num_errors, n_tests, cyc, steps, recal_k, w, n, n_dreq, n_poll;
	fhsp_if bus_if ();
	fhsp_device #(.STABLE_CYC(STABLE)) i_fhsp_device (.clock_i(clock_i),
		.rst_i(rst_i), .bus(bus_if), .drive_ready_i(drive_ready_i),
		.track0_i(track0_i), .head_load_out_o(head_o),
		.step_pulse_out_o(step_o), .seek_dir_o(dir_o),
		.osc_enable_o(osc_o), .clock_stable_o(stable_o));
	fhsp_host i_fhsp_host (.clock_i(clock_i), .rst_i(rst_i), .bus(bus_if),
		.start_i(start_i), .cmd_i(cmd_i), .param0_i(p0_i), .param1_i(p1_i),
		.nparam_i(np_i), .busy_o(busy_o), .result_o(res_o),
		.result_valid_o(valid_o));
	fhsp_bus_checker i_fhsp_bus_checker (.clock_i(clock_i), .rst_i(rst_i),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
		.rd(bus_if.rd), .rdata(bus_if.rdata),
		.dma_service_req(bus_if.dma_service_req), .dma_ack(bus_if.dma_ack));
	task automatic check(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// The model expects one result byte from refused and read commands.
	task automatic run_cmd(input logic [7:0] c, p0, p1, input logic [1:0] np);
		@(posedge clock_i);
		cmd_i <= c;
		p0_i <= p0;
		p1_i <= p1;
		np_i <= np;
		start_i <= 1'b1;
		@(posedge clock_i);
		start_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		w = 0;
		while (busy_o !== 1'b0 && w < 5000) begin
			@(posedge clock_i);
			w++;
		end
		repeat (4) @(posedge clock_i);
		check("host done", 1, w < 5000);
		check("result count", exp_q.size(), got_q.size());
		while (exp_q.size() > 0 && got_q.size() > 0) begin
			check("result", exp_q.pop_front(), got_q.pop_front());
		end
		exp_q.delete();
		got_q.delete();
	endtask
	// ------
	// Stimulus
	// ------
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (valid_o === 1'b1) got_q.push_back(res_o);
		if (step_o === 1'b1 && step_prev !== 1'b1) begin
			steps++;
			check("step direction", exp_dir, dir_o);
		end
		step_prev = step_o;
		if (bus_if.dma_service_req === 1'b1) n_dreq++;
		if (stat_pend && bus_if.rdata[FHSP_BIT_POLL] === 1'b1) n_poll++;
		stat_pend = bus_if.rd === 1'b1 && bus_if.addr == FHSP_PORT_STATUS;
		if (recal_k > 0 && steps >= recal_k) track0_i <= 1'b1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		rst_i = 1'b1;
		start_i = 1'b0;
		drive_ready_i = 1'b1;
		track0_i = 1'b0;
		cmd_i = 8'h00;
		p0_i = 8'h00;
		p1_i = 8'h00;
		np_i = 2'h0;
		exp_dir = 1'b1;
		step_prev = 1'b0;
		stat_pend = 1'b0;
		void'($urandom(32'h2d44dcfa));
		repeat (8) @(posedge clock_i);
		check("osc enable", 1, osc_o);
		check("seek dir reset", 1, dir_o);
		check("head load reset", 0, head_o);
		check("stable reset", 0, stable_o);
		rst_i <= 1'b0;
		while (stable_o !== 1'b1 && w < 100) begin
			@(posedge clock_i);
			w++;
		end
		check("settle", 1, w >= STABLE - 1 && w <= STABLE + 1);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			n = $urandom;
			if (i < 3) n = {n[2:0], i == 0 ? FHSP_CMD_SCAN_A :
				i == 1 ? FHSP_CMD_SCAN_B : FHSP_CMD_SCAN_C};
			while (n[7:0] inside {8'h03, 8'h07, 8'h0f, 8'h06, 8'h13, 8'h17})
				n = $urandom;
			exp_q.push_back(FHSP_ST_INVALID);
			run_cmd(n[7:0], 8'h00, 8'h00, 2'h0);
		end
		$display("unsupported test done");
		n = $urandom;
		run_cmd(FHSP_CMD_CONFIG, {3'h0, 1'b1, n[3:0]}, 8'h00, 2'h1);
		run_cmd(FHSP_CMD_SPECIFY, n[15:8], {n[22:16], 1'b0}, 2'h2);
		check("no stray steps", 0, steps);
		$display("setup test done");
		thr = n[3:0];
		n_dreq = 0;
		n_poll = 0;
		exp_q.push_back({1'b1, 3'h0, thr});
		run_cmd(FHSP_CMD_READ, n[31:24], 8'h00, 2'h1);
		check("dma requests", 1, n_dreq);
		check("polled flag in dma", 0, n_poll);
		run_cmd(FHSP_CMD_SPECIFY, n[15:8], {n[22:16], 1'b1}, 2'h2);
		n_dreq = 0;
		n_poll = 0;
		exp_q.push_back({1'b1, 3'h0, thr});
		run_cmd(FHSP_CMD_READ, n[31:24], 8'h00, 2'h1);
		check("dma requests polled", 0, n_dreq);
		check("polled flag seen", 1, n_poll > 0);
		$display("read test done");
		n = 3 + $urandom % 6;
		run_cmd(FHSP_CMD_SEEK, 8'h00, n[7:0], 2'h2);
		repeat (1000) @(posedge clock_i);
		check("seek steps", n, steps);
		$display("seek test done");
		steps = 0;
		exp_dir = 1'b0;
		recal_k = 2 + $urandom % 4;
		run_cmd(FHSP_CMD_RECAL, 8'h00, 8'h00, 2'h1);
		repeat (1000) @(posedge clock_i);
		check("recal steps", recal_k, steps);
		$display("recal test done");
		run_cmd(8'h17, 8'h00, 8'h00, 2'h0);
		check("osc in powerdown", 0, osc_o);
		check("stable in powerdown", 0, stable_o);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		check("osc after reset", 1, osc_o);
		rst_i <= 1'b0;
		w = 0;
		while (stable_o !== 1'b1 && w < 100) begin
			@(posedge clock_i);
			w++;
		end
		check("resettle", 1, w >= STABLE - 1 && w <= STABLE + 1);
		exp_q.push_back(FHSP_ST_INVALID);
		run_cmd(8'h00, 8'h00, 8'h00, 2'h0);
		$display("powerdown test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
